/* rxte_map.vh */
// rxte_map.vh: register offsets, field positions, reset values and timing counts
// for the radio receive task engine; included by the engine file only.
`ifndef RXTE_MAP_VH
`define RXTE_MAP_VH

// apb register byte offsets
`define RXTE_CTRL_OFF      12'h000
`define RXTE_CMD_OFF       12'h004
`define RXTE_TONE_OFF      12'h008
`define RXTE_SEARCH_OFF    12'h00C
`define RXTE_ENTRY_OFF     12'h010
`define RXTE_STATUS_OFF    12'h014
`define RXTE_COUNT_OFF     12'h018

// control register fields
`define RXTE_CTRL_TONE     0
`define RXTE_CTRL_ADDRLEN  1
`define RXTE_CTRL_MODE_LO  2
`define RXTE_CTRL_MODE_HI  3
`define RXTE_CTRL_REPEAT   4
`define RXTE_CTRL_START    5
`define RXTE_CTRL_STOP_LO  6
`define RXTE_CTRL_STOP_HI  7
`define RXTE_CTRL_FLCRC    8
`define RXTE_CTRL_FLEMPTY  9
`define RXTE_CTRL_CHAN_LO  16
`define RXTE_CTRL_CHAN_HI  22

// command codes written to the command register
`define RXTE_CMD_RX        8'h01
`define RXTE_CMD_TX        8'h02
`define RXTE_CMD_STOP      8'h03

// end causes
`define RXTE_END_OK        8'h00
`define RXTE_END_RXTIMEOUT 8'h01
`define RXTE_END_NOSYNC    8'h02
`define RXTE_END_MODUNF    8'hF9

// tone defaults: 48 us in 32 MHz ticks
`define RXTE_TONE_US       48
`define RXTE_TONE_TICKS    16'h0600
`define RXTE_TRIM_MAX      16'h1000
`define RXTE_SYNTH_TICKS   16'h1400

// ref_clk 100 MHz against the 32 MHz tick base
`define RXTE_CLK_MHZ       100
`define RXTE_TICK_MHZ      32

`define RXTE_ENTRIES       8
`endif

/* rxte_engine.v */
// rxte_engine.v: start tone and basic-mode receive task of the radio link engine.
// assumes an apb master on ref_clk and a demodulator delivering bytes with rx_sync pulses.
`timescale 1ns/1ps
`include "rxte_map.vh"

module rxte_engine (
  input  wire        ref_clk,        // 100 MHz clock
  input  wire        rstn,           // async active-low reset
  input  wire        psel,           // apb select
  input  wire        penable,        // apb access phase
  input  wire        pwrite,         // apb direction
  input  wire [11:0] paddr,          // apb byte address
  input  wire [31:0] pwdata,         // apb write data
  output reg  [31:0] prdata,         // apb read data
  output reg         pready,         // apb ready
  output reg         pslverr,        // apb error on unmapped address
  input  wire        rx_sync,        // sync found pulse from demodulator, async
  input  wire [1:0]  rx_sync_id,     // which sync word matched
  input  wire        rx_byte_vld,    // byte strobe level toggled per byte, async
  input  wire [7:0]  rx_byte,        // received byte, stable around toggle
  input  wire        rx_pkt_end,     // crc bytes consumed, level, async
  input  wire        rx_crc_ok,      // crc over the packet with seed, valid at end
  input  wire        timer_ev1,      // timer event 1 level, async
  input  wire        timer_ev2,      // timer event 2 level, async
  input  wire        mod_underflow,  // modulator underflow level, async
  input  wire        fifo_full,      // rx fifo full level, async
  output reg  [6:0]  synth_chan,     // channel tuned by the synthesizer
  output reg         synth_on,       // synthesizer enabled
  output reg  [15:0] synth_wait,     // synthesizer startup ticks after trim
  output reg         tone_on,        // tone replaces preamble
  output reg         rx_on,          // receiver searching or receiving
  output reg         timer_capture,  // capture pulse at sync
  output reg         fifo_discard,   // discard current packet from rx fifo
  output reg  [7:0]  result_byte,    // status result byte, msb is crc ok
  output reg         rx_good_event,  // packet with payload and good crc
  output reg         rx_empty_event, // empty packet with good crc
  output reg         rx_bad_event,   // crc failed packet
  output reg         rx_overflow_event, // packet lost to full fifo
  output reg         task_finished_event, // task ended
  output reg         sem_release     // semaphores freed at task end
);

  localparam [7:0] S_IDLE = 8'b0000_0001;
  localparam [7:0] S_TONE = 8'b0000_0010;
  localparam [7:0] S_SRCH = 8'b0000_0100;
  localparam [7:0] S_LEN  = 8'b0000_1000;
  localparam [7:0] S_ADDR = 8'b0001_0000;
  localparam [7:0] S_BODY = 8'b0010_0000;
  localparam [7:0] S_DONE = 8'b0100_0000;
  localparam [7:0] S_WAIT = 8'b1000_0000;

  // -----------------------------------------------------------------
  // reset and input synchronisers
  // -----------------------------------------------------------------
  reg       rst_a_r, rst_b_r;
  wire      rst_n = rst_b_r;
  // release reset through two flops so every flop leaves reset together
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_a_r <= 1'b0;
      rst_b_r <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_b_r <= rst_a_r;
    end
  end

  reg [6:0] sy1_r, sy2_r;
  reg       sync_d_r, byte_d_r;
  reg [10:0] dat1_r, dat2_r;  // crc verdict, sync id and byte pass the same two stages
  // first stage is read only by the second stage
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sy1_r    <= 7'h00;
      sy2_r    <= 7'h00;
      sync_d_r <= 1'b0;
      byte_d_r <= 1'b0;
      dat1_r   <= 11'h000;
      dat2_r   <= 11'h000;
    end else begin
      sy1_r    <= {fifo_full, mod_underflow, timer_ev2, timer_ev1, rx_pkt_end, rx_byte_vld, rx_sync};
      sy2_r    <= sy1_r;
      sync_d_r <= sy2_r[0];
      byte_d_r <= sy2_r[1];
      dat1_r   <= {rx_crc_ok, rx_sync_id, rx_byte};
      dat2_r   <= dat1_r;
    end
  end
  wire sync_pls = sy2_r[0] & ~sync_d_r;
  wire byte_pls = sy2_r[1] ^ byte_d_r;  // byte data is held long past the toggle
  wire pkt_end  = sy2_r[2];
  wire ev1      = sy2_r[3];
  wire ev2      = sy2_r[4];
  wire modunf   = sy2_r[5];
  wire ffull    = sy2_r[6];
  // data lines change with their strobe and are held long after, so two stages keep them aligned with it
  wire [7:0] byte_s = dat2_r[7:0];
  wire [1:0] sid_s  = dat2_r[9:8];
  wire       crc_s  = dat2_r[10];

  // -----------------------------------------------------------------
  // 32 MHz tick enable from the 100 MHz clock (phase accumulator)
  // -----------------------------------------------------------------
  reg [7:0] acc_r;
  wire [8:0] acc_sum = {1'b0, acc_r} + 9'd`RXTE_TICK_MHZ;
  wire      tick = (acc_sum >= `RXTE_CLK_MHZ);
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      acc_r <= 8'h00;
    else if (tick)
      acc_r <= acc_sum[7:0] - 8'd`RXTE_CLK_MHZ;
    else
      acc_r <= acc_sum[7:0];
  end

  // -----------------------------------------------------------------
  // software registers
  // -----------------------------------------------------------------
  reg [31:0] ctrl_r;
  reg [15:0] tone_len_r, trim_r;
  reg [31:0] search_r;
  reg [7:0]  entry_addr_r [0:7];
  reg [7:0]  entry_max_r  [0:7];
  reg [3:0]  entry_en_r   [0:7];   // one enable bit per sync word
  reg [15:0] good_cnt_r   [0:7];
  reg [15:0] bad_cnt_r    [0:7];
  reg [2:0]  sel_r;                // entry viewed through the entry window
  reg [7:0]  end_cause_r;
  reg [7:0]  state_r;
  reg        cmd_rx, cmd_stop;

  wire       tone_en  = ctrl_r[`RXTE_CTRL_TONE];
  wire       addr_len = ctrl_r[`RXTE_CTRL_ADDRLEN];
  wire       var_len  = ctrl_r[`RXTE_CTRL_MODE_LO];
  wire       repeat_t = ctrl_r[`RXTE_CTRL_REPEAT];
  wire       start_c  = ctrl_r[`RXTE_CTRL_START];
  wire       stop11   = (ctrl_r[`RXTE_CTRL_STOP_HI:`RXTE_CTRL_STOP_LO] == 2'b11);

  wire       apb_wr = psel & penable & pwrite & pready;
  wire       apb_rd = psel & ~penable & ~pwrite;

  reg  [2:0] cnt_bump_idx;
  reg        cnt_good, cnt_bad;
  integer    i;
  // register writes; counters are bumped by the engine, software only reads them
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r     <= 32'h0000_0000;
      tone_len_r <= `RXTE_TONE_TICKS;
      trim_r     <= `RXTE_TONE_TICKS;
      search_r   <= 32'h0000_0000;
      sel_r      <= 3'h0;
      cmd_rx     <= 1'b0;
      cmd_stop   <= 1'b0;
      for (i = 0; i < `RXTE_ENTRIES; i = i + 1) begin
        entry_addr_r[i] <= 8'h00;
        entry_max_r[i]  <= 8'h00;
        entry_en_r[i]   <= 4'h0;
        good_cnt_r[i]   <= 16'h0000;
        bad_cnt_r[i]    <= 16'h0000;
      end
    end else begin
      cmd_rx   <= apb_wr && paddr == `RXTE_CMD_OFF && pwdata[7:0] == `RXTE_CMD_RX;
      cmd_stop <= apb_wr && paddr == `RXTE_CMD_OFF && pwdata[7:0] == `RXTE_CMD_STOP;
      if (apb_wr) begin
        if (paddr == `RXTE_CTRL_OFF) begin
          ctrl_r <= pwdata;
        end else if (paddr == `RXTE_TONE_OFF) begin
          tone_len_r <= pwdata[15:0];
          trim_r     <= pwdata[31:16];
        end else if (paddr == `RXTE_SEARCH_OFF) begin
          search_r <= pwdata;
        end else if (paddr == `RXTE_ENTRY_OFF) begin
          sel_r                  <= pwdata[30:28];
          entry_addr_r[pwdata[30:28]] <= pwdata[7:0];
          entry_max_r[pwdata[30:28]]  <= pwdata[15:8];
          entry_en_r[pwdata[30:28]]   <= pwdata[19:16];
        end
      end
      if (cnt_good)
        good_cnt_r[cnt_bump_idx] <= good_cnt_r[cnt_bump_idx] + 16'h0001;
      if (cnt_bad)
        bad_cnt_r[cnt_bump_idx] <= bad_cnt_r[cnt_bump_idx] + 16'h0001;
    end
  end

  // apb answer: no wait state, reads latched at setup
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~(paddr == `RXTE_CTRL_OFF || paddr == `RXTE_CMD_OFF ||
                 paddr == `RXTE_TONE_OFF || paddr == `RXTE_SEARCH_OFF || paddr == `RXTE_ENTRY_OFF ||
                 paddr == `RXTE_STATUS_OFF || paddr == `RXTE_COUNT_OFF);
      if (apb_rd) begin
        if (paddr == `RXTE_CTRL_OFF)
          prdata <= ctrl_r;
        else if (paddr == `RXTE_TONE_OFF)
          prdata <= {trim_r, tone_len_r};
        else if (paddr == `RXTE_SEARCH_OFF)
          prdata <= search_r;
        else if (paddr == `RXTE_ENTRY_OFF)
          prdata <= {1'b0, sel_r, 8'h00, entry_en_r[sel_r], entry_max_r[sel_r], entry_addr_r[sel_r]};
        else if (paddr == `RXTE_STATUS_OFF)
          prdata <= {state_r, result_byte, 8'h00, end_cause_r};
        else if (paddr == `RXTE_COUNT_OFF)
          prdata <= {bad_cnt_r[sel_r], good_cnt_r[sel_r]};
        else
          prdata <= 32'h0000_0000;
      end
    end
  end

  // -----------------------------------------------------------------
  // entry lookup: first enabled entry for the sync word, matching if asked
  // -----------------------------------------------------------------
  function [3:0] rxte_find;  // {found, index}
    input [1:0] sid;
    input       use_addr;
    input [7:0] abyte;
    integer k;
    reg   [3:0] res;
    begin
      res = 4'h0;
      for (k = `RXTE_ENTRIES - 1; k >= 0; k = k - 1)
        if (entry_en_r[k][sid] && (!use_addr || entry_addr_r[k] == abyte))
          res = {1'b1, k[2:0]};
      rxte_find = res;
    end
  endfunction

  // -----------------------------------------------------------------
  // task sequencer
  // -----------------------------------------------------------------
  reg [31:0] tmr_r;       // tone and search timer in 32 MHz ticks
  reg        first_r;     // still the first sync search of the task
  reg [7:0]  len_r;       // payload bytes left between address and crc
  reg [7:0]  pkt_len_r;   // length including address
  reg [2:0]  ent_r;
  reg [1:0]  sid_r;
  reg        ovf_r;
  wire       ev2_live = stop11 && (start_c || first_r);
  wire       lim_live = search_r != 32'h0 && !(stop11 && (start_c || first_r));
  wire [3:0] hit_any  = rxte_find(sid_r, 1'b0, 8'h00);
  wire [3:0] hit_addr = rxte_find(sid_r, 1'b1, byte_s);
  wire       empty_p  = (pkt_len_r == {7'h00, addr_len});
  wire       flushed  = (!crc_s && ctrl_r[`RXTE_CTRL_FLCRC]) || (empty_p && ctrl_r[`RXTE_CTRL_FLEMPTY]);

  // ends the task with a cause; events are single-cycle pulses
  task finish;
    input [7:0] cause;
    begin
      end_cause_r         <= cause;
      task_finished_event <= 1'b1;
      sem_release         <= 1'b1;
      rx_on               <= 1'b0;
      synth_on            <= 1'b0;
      tone_on             <= 1'b0;
      state_r             <= S_IDLE;
    end
  endtask

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      tmr_r <= 32'h0; first_r <= 1'b0; len_r <= 8'h00; pkt_len_r <= 8'h00;
      ent_r <= 3'h0; sid_r <= 2'h0; ovf_r <= 1'b0; end_cause_r <= `RXTE_END_OK;
      synth_chan <= 7'h00; synth_on <= 1'b0; synth_wait <= 16'h0000; tone_on <= 1'b0;
      rx_on <= 1'b0; timer_capture <= 1'b0; fifo_discard <= 1'b0; result_byte <= 8'h00;
      rx_good_event <= 1'b0; rx_empty_event <= 1'b0; rx_bad_event <= 1'b0;
      rx_overflow_event <= 1'b0; task_finished_event <= 1'b0; sem_release <= 1'b0;
      cnt_good <= 1'b0; cnt_bad <= 1'b0; cnt_bump_idx <= 3'h0;
    end else begin
      timer_capture <= 1'b0; fifo_discard <= 1'b0; rx_good_event <= 1'b0;
      rx_empty_event <= 1'b0; rx_bad_event <= 1'b0; rx_overflow_event <= 1'b0;
      task_finished_event <= 1'b0; sem_release <= 1'b0; cnt_good <= 1'b0; cnt_bad <= 1'b0;
      if (tick && tmr_r != 32'h0)
        tmr_r <= tmr_r - 32'h1;
      case (state_r)
        S_IDLE: begin
          if (cmd_rx) begin
            synth_chan <= ctrl_r[`RXTE_CTRL_CHAN_HI:`RXTE_CTRL_CHAN_LO];
            synth_on   <= 1'b1;
            first_r    <= 1'b1;
            // trim overlaps tone with synth settling; clamp guards a bad host value
            synth_wait <= tone_en ? `RXTE_SYNTH_TICKS - (trim_r > `RXTE_TRIM_MAX ? `RXTE_TRIM_MAX : trim_r)
                                  : `RXTE_SYNTH_TICKS;
            if (tone_en) begin
              tone_on <= 1'b1;
              tmr_r   <= {16'h0000, tone_len_r};
              state_r <= S_TONE;
            end else begin
              rx_on   <= 1'b1;
              tmr_r   <= search_r;
              state_r <= S_SRCH;
            end
          end
        end
        S_TONE: begin
          if (modunf)
            finish(`RXTE_END_MODUNF);
          else if (tmr_r == 32'h0) begin
            tone_on <= 1'b0;
            rx_on   <= 1'b1;
            tmr_r   <= search_r;
            state_r <= S_SRCH;
          end
        end
        S_SRCH: begin
          if (cmd_stop || (ev2_live && ev2))
            finish(`RXTE_END_RXTIMEOUT);
          else if (lim_live && tmr_r == 32'h0 && search_r != 32'h0)
            finish(`RXTE_END_NOSYNC);
          else if (sync_pls) begin
            timer_capture <= 1'b1;
            sid_r <= sid_s;
            ovf_r <= 1'b0;
            state_r <= var_len ? S_LEN : S_ADDR;
          end
        end
        S_LEN: begin
          if (byte_pls) begin
            pkt_len_r <= byte_s;
            if (byte_s < {7'h00, addr_len}) begin
              tmr_r   <= search_r;
              state_r <= S_SRCH;
            end else
              state_r <= S_ADDR;
          end
        end
        S_ADDR: begin
          if (!addr_len || byte_pls) begin
            if (addr_len ? !hit_addr[3] : !hit_any[3]) begin
              tmr_r   <= search_r;
              state_r <= S_SRCH;
            end else begin
              ent_r <= addr_len ? hit_addr[2:0] : hit_any[2:0];
              if (!var_len) begin
                pkt_len_r <= entry_max_r[addr_len ? hit_addr[2:0] : hit_any[2:0]];
                len_r <= entry_max_r[addr_len ? hit_addr[2:0] : hit_any[2:0]] - {7'h00, addr_len};
                state_r <= S_BODY;
              end else if (pkt_len_r > entry_max_r[addr_len ? hit_addr[2:0] : hit_any[2:0]]) begin
                tmr_r   <= search_r;
                state_r <= S_SRCH;
              end else begin
                len_r   <= pkt_len_r - {7'h00, addr_len};
                state_r <= S_BODY;
              end
            end
          end
        end
        S_BODY: begin
          if (ffull)
            ovf_r <= 1'b1;
          if (byte_pls && len_r != 8'h00)
            len_r <= len_r - 8'h01;
          if (pkt_end)
            state_r <= S_DONE;
        end
        S_DONE: begin
          first_r      <= 1'b0;
          cnt_bump_idx <= ent_r;
          result_byte  <= {crc_s, 7'h00};
          fifo_discard <= flushed | ovf_r;
          if (ovf_r && !flushed)
            rx_overflow_event <= 1'b1;
          else if (!crc_s)
            rx_bad_event <= 1'b1;
          else if (empty_p)
            rx_empty_event <= 1'b1;
          else
            rx_good_event <= 1'b1;
          cnt_good <= crc_s;
          cnt_bad  <= !crc_s;
          state_r  <= S_WAIT;
        end
        S_WAIT: begin
          // wait for the end level to drop so one packet is counted once
          if (!pkt_end) begin
            if (!repeat_t)
              finish(`RXTE_END_OK);
            else if (!start_c || ev1) begin
              tmr_r   <= search_r;
              state_r <= S_SRCH;
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

endmodule

/* rxte_monitor.sv */
// rxte_monitor.sv: port-level checker for the radio receive task engine.
// assumes it is bound to rxte_engine and sees only that module's ports.
`timescale 1ns/1ps
// ----------------------------------------
// checker module
// ----------------------------------------
module rxte_monitor (
  input wire logic       ref_clk,             // 100 MHz clock
  input wire logic       rstn,                // async active-low reset
  input wire logic       psel,                // apb select
  input wire logic       penable,             // apb access phase
  input wire logic       pready,              // apb ready
  input wire logic       pslverr,             // apb error
  input wire logic       rx_sync,             // sync found from demodulator
  input wire logic       rx_on,               // receiver active
  input wire logic       timer_capture,       // capture pulse
  input wire logic       fifo_discard,        // fifo discard pulse
  input wire logic [7:0] result_byte,         // status result byte
  input wire logic       rx_good_event,       // good packet
  input wire logic       rx_empty_event,      // empty packet
  input wire logic       rx_bad_event,        // bad packet
  input wire logic       rx_overflow_event,   // packet lost to full fifo
  input wire logic       task_finished_event, // task ended
  input wire logic       sem_release          // semaphores freed
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // apb answers in the cycle after setup, for one cycle only
  a_apb_ready_next: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  a_apb_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
  a_apb_err_ready: assert property (pslverr |-> pready) else $error("slave error without ready");
  // task end frees semaphores in the same cycle
  a_end_frees_sem: assert property (task_finished_event |-> sem_release) else $error("end without release");
  // at most one packet event per cycle
  a_one_pkt_event: assert property ($onehot0({rx_good_event, rx_empty_event, rx_bad_event,
    rx_overflow_event})) else $error("two packet events at once");
  // sync edge in search is timestamped a few cycles later
  a_sync_capture: assert property ($rose(rx_sync) && rx_on |-> ##[2:5] timer_capture)
    else $error("sync not captured");
  // a discard only comes with a flushed or lost packet
  a_discard_cause: assert property (fifo_discard |-> rx_bad_event || rx_empty_event || rx_overflow_event)
    else $error("discard without cause");
  // crc result lands in the msb of the result byte
  a_crc_good_msb: assert property (rx_good_event |-> ##[0:1] result_byte[7]) else $error("good crc not in msb");
  a_crc_bad_msb: assert property (rx_bad_event |-> ##[0:1] !result_byte[7]) else $error("bad crc not in msb");
  c_good: cover property (rx_good_event);
  c_bad_flush: cover property (rx_bad_event && fifo_discard);
  c_done: cover property (task_finished_event);
  c_overflow: cover property (rx_overflow_event && fifo_discard);
endmodule

bind rxte_engine rxte_monitor rxte_monitor_i (.ref_clk, .rstn, .psel, .penable, .pready, .pslverr, .rx_sync,
  .rx_on, .timer_capture, .fifo_discard, .result_byte, .rx_good_event, .rx_empty_event, .rx_bad_event,
  .rx_overflow_event, .task_finished_event, .sem_release);

/* rxte_radio.sv */
// rxte_radio.sv: behavioural remote transmitter as seen through the demodulator.
// assumes its tasks are called just after a rising edge of ref_clk.
`timescale 1ns/1ps
// ----------------------------------------
// air-side partner model
// ----------------------------------------
module rxte_radio (
  input  wire logic       ref_clk,     // pacing clock
  output logic            rx_sync,     // sync found pulse
  output logic [1:0]      rx_sync_id,  // matched sync word
  output logic            rx_byte_vld, // toggles once per byte
  output logic [7:0]      rx_byte,     // byte value
  output logic            rx_pkt_end,  // end of packet level
  output logic            rx_crc_ok    // crc verdict at end
);
  initial begin
    rx_sync = 1'b0; rx_sync_id = 2'b00; rx_byte_vld = 1'b0;
    rx_byte = 8'h00; rx_pkt_end = 1'b0; rx_crc_ok = 1'b0;
  end
  // hold each byte 6 cycles, then show the inverse so stale data never looks valid
  task automatic put(input logic [7:0] b);
    @(posedge ref_clk);
    rx_byte <= b;
    rx_byte_vld <= ~rx_byte_vld;
    repeat (6) @(posedge ref_clk);
    rx_byte <= ~b;
  endtask
  // length byte first, then address, then payload, then crc verdict
  task automatic send_pkt(input logic [7:0] len, input logic [7:0] addr, input logic [7:0] npay, input logic ok);
    int i;
    @(posedge ref_clk) rx_sync <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rx_sync <= 1'b0;
    put(len);
    put(addr);
    for (i = 0; i < npay; i++) put(8'h30 + 8'(i));
    @(posedge ref_clk) rx_pkt_end <= 1'b1;
    rx_crc_ok <= ok;
    repeat (6) @(posedge ref_clk);
    rx_pkt_end <= 1'b0;
    rx_crc_ok <= ~ok;
    repeat (20) @(posedge ref_clk);
  endtask
endmodule

/* testbench.sv */
// testbench.sv: apb-driven receive task run against the air model.
// assumes rxte_engine, rxte_radio and the bound checker are compiled before it.
`timescale 1ns/1ps
module testbench;
  logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic er, rx_sync, rx_byte_vld, rx_pkt_end, rx_crc_ok, synth_on, tone_on, rx_on;
  logic ff, mu, t2;  // fifo full, modulator underflow and timer event 2 levels
  logic [1:0] rx_sync_id;
  logic [7:0] rx_byte, result_byte;
  logic [6:0] synth_chan;
  logic [15:0] synth_wait;
  logic [7:0] ev;
  int num_errors, samples_checked, cyc, n;
  int cnt [8];
  rxte_engine rxte_engine_i (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_sync, .rx_sync_id, .rx_byte_vld, .rx_byte, .rx_pkt_end, .rx_crc_ok, .timer_ev1(1'b0),
    .timer_ev2(t2), .mod_underflow(mu), .fifo_full(ff), .synth_chan, .synth_on, .synth_wait, .tone_on,
    .rx_on, .timer_capture(ev[0]), .fifo_discard(ev[1]), .result_byte, .rx_good_event(ev[2]),
    .rx_empty_event(ev[3]), .rx_bad_event(ev[4]), .rx_overflow_event(ev[5]), .task_finished_event(ev[6]),
    .sem_release(ev[7]));
  rxte_radio rxte_radio_i (.ref_clk, .rx_sync, .rx_sync_id, .rx_byte_vld, .rx_byte, .rx_pkt_end, .rx_crc_ok);
  // ----------------------------------------
  // clock, event tally and hang guard
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    for (int k = 0; k < 8; k++) if (ev[k] === 1'b1) cnt[k]++;
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("Error at %0t: timeout", $time);
      print_verdict();
    end
  end
  // ----------------------------------------
  // bus cycle, compare and closing
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // only pready or the bench timeout ends this wait
    do begin @(posedge ref_clk); end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0000_0000;
    ff = 1'b0;
    mu = 1'b0;
    t2 = 1'b0;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    apb(0, 12'h008, 0); chk(rd, {16'd1536, 16'd1536});
    apb(0, 12'hFFC, 0); chk({31'h0, er}, 1); chk(rd, 0);
    $display("test reset_map done");
    apb(1, 12'h008, 32'h0800_0040);
    apb(1, 12'h010, 32'h0001_08A5);
    apb(1, 12'h00C, 32'd1000);
    apb(1, 12'h000, 32'h0015_0117);
    apb(1, 12'h004, 32'h0000_0001);
    n = 0; while (tone_on !== 1'b1 && n < 100) begin @(posedge ref_clk); n++; end
    chk({31'h0, tone_on}, 1);
    chk({31'h0, synth_on}, 1);
    chk({16'h0, synth_wait}, 32'h0000_0C00);
    chk({25'h0, synth_chan}, 32'h0000_0015);
    n = 0; while (rx_on !== 1'b1 && n < 1000) begin @(posedge ref_clk); n++; end
    chk({31'h0, rx_on}, 1);
    $display("test start done");
    rxte_radio_i.send_pkt(8'd9, 8'hA5, 8'd8, 1'b1);
    rxte_radio_i.send_pkt(8'd4, 8'h3C, 8'd3, 1'b1);
    rxte_radio_i.send_pkt(8'd4, 8'hA5, 8'd3, 1'b1);
    ff <= 1'b1;
    rxte_radio_i.send_pkt(8'd4, 8'hA5, 8'd3, 1'b1);
    ff <= 1'b0;
    rxte_radio_i.send_pkt(8'd4, 8'hA5, 8'd3, 1'b0);
    rxte_radio_i.send_pkt(8'd1, 8'hA5, 8'd0, 1'b1);
    n = 0; while (cnt[6] == 0 && n < 5000) begin @(posedge ref_clk); n++; end
    chk(cnt[0], 6);
    chk(cnt[1], 2);
    chk(cnt[2], 1);
    chk(cnt[3], 1);
    chk(cnt[4], 1);
    chk(cnt[5], 1);
    chk(cnt[6], 1);
    apb(0, 12'h014, 0); chk({24'h0, rd[7:0]}, 32'h0000_0002);
    chk({31'h0, rd[23]}, 1);
    chk({24'h0, result_byte}, 32'h0000_0080);
    apb(0, 12'h018, 0); chk(rd, 32'h0001_0003);
    $display("test packets done");
    // tone task cut short by a modulator underflow
    apb(1, 12'h000, 32'h0015_0001);
    mu <= 1'b1;
    apb(1, 12'h004, 32'h0000_0001);
    n = 0; while (cnt[6] < 2 && n < 500) begin @(posedge ref_clk); n++; end
    mu <= 1'b0;
    apb(0, 12'h014, 0); chk({24'h0, rd[7:0]}, 32'h0000_00F9);
    // stop condition 11, start condition 0: timer event 2 ends the first search
    apb(1, 12'h000, 32'h0015_00C2);
    apb(1, 12'h004, 32'h0000_0001);
    n = 0; while (rx_on !== 1'b1 && n < 100) begin @(posedge ref_clk); n++; end
    t2 <= 1'b1;
    n = 0; while (cnt[6] < 3 && n < 100) begin @(posedge ref_clk); n++; end
    t2 <= 1'b0;
    apb(0, 12'h014, 0); chk({24'h0, rd[7:0]}, 32'h0000_0001);
    chk(cnt[7], 3);
    $display("test task_end done");
    print_verdict();
  end
endmodule
